/* core/ahsp_pkg.sv */
// Package with constants and carrier types of the host strobe port
package ahsp_pkg;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 8;
  localparam int NUM_PAIRS = 3;
  localparam int CONV_CYCLES_DEF = 60;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam int UPPER_LSB = 8;
  localparam int SER_BITS = 16;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } ahsp_strobe_type;

  typedef enum logic [1:0] {
    AHSP_IDLE,
    AHSP_CONV,
    AHSP_LATCH
  } ahsp_conv_state_type;
endpackage : ahsp_pkg

/* core/ahsp_buf.sv */
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/10ps
module ahsp_buf
  import ahsp_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem_ff [BUF_DEPTH];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  wire push = in_valid_in && (count_ff != 2'h2);
  wire pop = out_ready_in && (count_ff != 2'h0);

  // Flags straight from the count
  assign in_ready_out = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);
  assign out_data_out = mem_ff[rd_ptr_ff];

  // Pointer and storage update
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data_in;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : ahsp_buf

/* core/ahsp_port.sv */
// Host strobe port: parallel/serial read, control write, reference enable, busy
// Summary of operation
// - Chip select is active low and frames every host transfer.
// - In parallel mode with chip select and read low, the result is driven on the data bus.
// - In parallel mode with mode select high and chip select and write low, the upper data lines write the control register.
// - Control writes are taken only with mode select high and chip select and write low.
// - With mode select low, the write pin is a reference-enable level, not a strobe.
// - In pin mode a low reference-enable level turns the internal reference off.
// - In pin mode a high reference-enable level turns the internal reference on.
// - In serial mode chip select frames the read, and its fall presents the MSB first.
// - Busy rises when a conversion starts and stays high until results are latched.
// - A rising conversion-start edge while idle puts the pair in hold and starts its conversion.
// - Serial/parallel select low picks parallel, high picks serial.
`timescale 1ns/10ps
module ahsp_port
  import ahsp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic CS_N_IN,
  input wire logic RD_N_IN,
  input wire logic WRITE_STROBE_OR_REF_ENABLE_IN,
  input wire logic HW_SW_SELECT_IN,
  input wire logic SERIAL_PARALLEL_SELECT_IN,
  input wire logic [NUM_PAIRS-1:0] CONVERSION_START_IN,
  input wire logic [DATA_W-1:0] DB_IN,
  input wire logic [DATA_W-1:0] CONV_RESULT_IN,
  input wire logic SERIAL_CLK_IN,
  output logic [DATA_W-1:0] DB_OUT,
  output logic DB_OE_OUT,
  output logic SERIAL_DOUT_OUT,
  output logic BUSY_OUT,
  output logic [NUM_PAIRS-1:0] HOLD_OUT,
  output logic INT_REF_ON_OUT,
  output logic [CTRL_W-1:0] CTRL_REG_OUT,
  output logic CTRL_WRITE_OUT
);
  // Registers and internal nets
  ahsp_strobe_type strb;
  ahsp_conv_state_type state_ff;
  ahsp_conv_state_type nxt_state;
  logic [NUM_PAIRS-1:0] cstart_ff;
  logic [NUM_PAIRS-1:0] hold_ff;
  logic [15:0] cnt_ff;
  logic cs_n_d_ff;
  logic sclk_d_ff;
  logic wr_d_ff;
  logic [DATA_W-1:0] shift_ff;
  logic [DATA_W-1:0] db_ff;
  logic oe_ff;
  logic sdout_ff;
  logic busy_ff;
  logic iref_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic ctrl_wr_ff;
  logic buf_ready;
  logic buf_valid;
  logic [DATA_W-1:0] buf_data;

  // Both active-low strobes asserted together
  function automatic logic both_low(input logic a_n, input logic b_n);
    return !a_n && !b_n;
  endfunction : both_low

  // High-to-low step between the last sample and the present one
  function automatic logic fell(input logic prev, input logic now);
    return prev && !now;
  endfunction : fell

  // Strobe bundle and mode decode
  assign strb = '{cs_n: CS_N_IN, rd_n: RD_N_IN, wr_n: WRITE_STROBE_OR_REF_ENABLE_IN};
  wire par_mode = !SERIAL_PARALLEL_SELECT_IN;
  wire par_rd = par_mode && both_low(strb.cs_n, strb.rd_n);
  wire wr_low = both_low(strb.cs_n, strb.wr_n);
  wire ctrl_take = par_mode && HW_SW_SELECT_IN && wr_low;
  wire ctrl_edge = ctrl_take && !wr_d_ff;
  wire [CTRL_W-1:0] ctrl_val = DB_IN[UPPER_LSB +: CTRL_W];
  wire par_first = par_rd && !oe_ff;
  wire [DATA_W-1:0] nxt_db = buf_valid ? buf_data : db_ff;
  wire [NUM_PAIRS-1:0] start_rise = CONVERSION_START_IN & ~cstart_ff;
  wire start_any = |start_rise;
  wire conv_done = (state_ff == AHSP_CONV) && (cnt_ff == 16'(CONV_CYCLES - 1));
  wire [15:0] nxt_cnt = (state_ff == AHSP_CONV) ? cnt_ff + 16'h0001 : 16'h0000;

  // Serial frame decode
  wire cs_fall = fell(cs_n_d_ff, strb.cs_n);
  wire sclk_fall = fell(sclk_d_ff, SERIAL_CLK_IN);
  wire ser_frame = SERIAL_PARALLEL_SELECT_IN && !strb.cs_n;
  wire ser_load = ser_frame && cs_fall;
  wire ser_shift = ser_frame && sclk_fall;
  wire buf_pop = par_first || ser_load;

  // Conversion sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      AHSP_IDLE: begin
        if (start_any) begin
          nxt_state = AHSP_CONV;
        end
      end
      AHSP_CONV: begin
        if (conv_done) begin
          nxt_state = AHSP_LATCH;
        end
      end
      AHSP_LATCH: begin
        if (buf_ready) begin
          nxt_state = AHSP_IDLE;
        end
      end
      default: nxt_state = AHSP_IDLE;
    endcase
  end

  // Results held until the host reads them
  ahsp_buf #(
    .WIDTH(DATA_W)
  ) u_buf (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .in_valid_in(state_ff == AHSP_LATCH),
    .in_ready_out(buf_ready),
    .in_data_in(CONV_RESULT_IN),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_pop),
    .out_data_out(buf_data)
  );

  // Sequencer state, start history, cycle count and busy
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff <= AHSP_IDLE;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
      cstart_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cstart_ff <= CONVERSION_START_IN;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_state != AHSP_IDLE);
    end
  end

  // Pairs in hold from the accepted start until the result is latched
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hold_ff <= '0;
    end else if (state_ff == AHSP_IDLE) begin
      hold_ff <= start_rise;
    end else if (nxt_state == AHSP_IDLE) begin
      hold_ff <= '0;
    end
  end

  // Read bus enable and result captured on the first read cycle
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      db_ff <= DATA_RST;
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= par_rd;
      if (par_first) begin
        db_ff <= nxt_db;
      end
    end
  end

  // Control register, one write per strobe assertion
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_ff <= CTRL_RST;
      ctrl_wr_ff <= 1'b0;
      wr_d_ff <= 1'b0;
    end else begin
      wr_d_ff <= ctrl_take;
      ctrl_wr_ff <= ctrl_edge;
      if (ctrl_edge) begin
        ctrl_ff <= ctrl_val;
      end
    end
  end

  // Internal reference follows the pin level only in pin mode
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      iref_ff <= 1'b1;
    end else if (!HW_SW_SELECT_IN) begin
      iref_ff <= WRITE_STROBE_OR_REF_ENABLE_IN;
    end
  end

  // Serial shifter, MSB presented on chip select fall
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cs_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0; // Idle low, no false fall after reset
      shift_ff <= DATA_RST;
      sdout_ff <= 1'b0;
    end else begin
      cs_n_d_ff <= strb.cs_n;
      sclk_d_ff <= SERIAL_CLK_IN;
      if (ser_load) begin
        shift_ff <= {buf_data[DATA_W-2:0], 1'b0};
        sdout_ff <= buf_data[DATA_W-1];
      end else if (ser_shift) begin
        sdout_ff <= shift_ff[DATA_W-1];
        shift_ff <= {shift_ff[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Outputs straight from flip-flops
  assign DB_OUT = db_ff;
  assign DB_OE_OUT = oe_ff;
  assign SERIAL_DOUT_OUT = sdout_ff;
  assign BUSY_OUT = busy_ff;
  assign HOLD_OUT = hold_ff;
  assign INT_REF_ON_OUT = iref_ff;
  assign CTRL_REG_OUT = ctrl_ff;
  assign CTRL_WRITE_OUT = ctrl_wr_ff;
endmodule : ahsp_port

/* sim/ahsp_chk.sv */
// Assertion checker for the host strobe port
`timescale 1ns/10ps
module ahsp_chk
  import ahsp_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic CS_N_IN,
  input wire logic RD_N_IN,
  input wire logic WRITE_STROBE_OR_REF_ENABLE_IN,
  input wire logic HW_SW_SELECT_IN,
  input wire logic SERIAL_PARALLEL_SELECT_IN,
  input wire logic [NUM_PAIRS-1:0] CONVERSION_START_IN,
  input wire logic [DATA_W-1:0] DB_IN,
  input wire logic DB_OE_OUT,
  input wire logic BUSY_OUT,
  input wire logic [NUM_PAIRS-1:0] HOLD_OUT,
  input wire logic INT_REF_ON_OUT,
  input wire logic [CTRL_W-1:0] CTRL_REG_OUT,
  input wire logic CTRL_WRITE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic wsel;
  // Write strobe qualified for a control write
  assign wsel = !CS_N_IN && !WRITE_STROBE_OR_REF_ENABLE_IN && HW_SW_SELECT_IN && !SERIAL_PARALLEL_SELECT_IN;
  // Start edge seen while idle, then conversion steps
  sequence start_s;
    !BUSY_OUT && (CONVERSION_START_IN & ~$past(CONVERSION_START_IN)) != '0;
  endsequence
  sequence conv_s;
    (BUSY_OUT && HOLD_OUT != '0) ##1 BUSY_OUT[*3] ##[1:1000] !BUSY_OUT;
  endsequence
  a_read_drive: assert property (!CS_N_IN && !RD_N_IN && !SERIAL_PARALLEL_SELECT_IN |=> DB_OE_OUT)
    else $error("bus not driven on read");
  a_bus_release: assert property ((CS_N_IN || RD_N_IN) [*2] |-> ##1 !DB_OE_OUT)
    else $error("bus not released");
  a_ctrl_take: assert property (wsel && !$past(wsel) |=> CTRL_WRITE_OUT && CTRL_REG_OUT == $past(DB_IN[15:8]))
    else $error("control write lost");
  a_ctrl_gate: assert property (!(wsel && !$past(wsel)) |=> !CTRL_WRITE_OUT)
    else $error("stray control write");
  a_ref_level: assert property (!HW_SW_SELECT_IN |=> INT_REF_ON_OUT == $past(WRITE_STROBE_OR_REF_ENABLE_IN))
    else $error("reference level wrong");
  a_ref_keep: assert property (HW_SW_SELECT_IN |=> $stable(INT_REF_ON_OUT))
    else $error("reference moved");
  a_busy_run: assert property (start_s |=> conv_s)
    else $error("busy sequence wrong");
  a_hold_busy: assert property (HOLD_OUT != '0 |-> BUSY_OUT)
    else $error("hold without busy");
endmodule : ahsp_chk
bind ahsp_port ahsp_chk u_chk (.REF_CLK_IN, .RST_IN, .CS_N_IN, .RD_N_IN, .WRITE_STROBE_OR_REF_ENABLE_IN,
  .HW_SW_SELECT_IN, .SERIAL_PARALLEL_SELECT_IN, .CONVERSION_START_IN, .DB_IN, .DB_OE_OUT, .BUSY_OUT,
  .HOLD_OUT, .INT_REF_ON_OUT, .CTRL_REG_OUT, .CTRL_WRITE_OUT);

/* sim/ahsp_core_mdl.sv */
// Converter core model, one new result per finished conversion
`timescale 1ns/10ps
module ahsp_core_mdl
  import ahsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic busy_in,
  output logic [DATA_W-1:0] result_out
);
  logic busy_ff;
  // Result steady while busy, steps after busy falls
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_ff <= 1'b0;
      result_out <= 16'ha5c0;
    end else begin
      busy_ff <= busy_in;
      if (busy_ff && !busy_in) begin
        result_out <= result_out + 16'h0001;
      end
    end
  end
endmodule : ahsp_core_mdl

/* sim/adc_host_strobe_port_tb.sv */
// Self-checking bench for the host strobe port
`timescale 1ns/10ps
module adc_host_strobe_port_tb;
  import ahsp_pkg::*;
  logic clk, rst, cs_n, rd_n, ws, hw, ser, sclk, oe, sdo, busy, wp, iref;
  logic [2:0] cst, hold;
  logic [15:0] db, res, dout;
  logic [7:0] creg;
  int err_count = 0, samples_checked = 0, cycles = 0;
  localparam int CONV_N = 4;
  ahsp_port #(.CONV_CYCLES(CONV_N)) u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WRITE_STROBE_OR_REF_ENABLE_IN(ws), .HW_SW_SELECT_IN(hw), .SERIAL_PARALLEL_SELECT_IN(ser),
    .CONVERSION_START_IN(cst), .DB_IN(db), .CONV_RESULT_IN(res), .SERIAL_CLK_IN(sclk), .DB_OUT(dout),
    .DB_OE_OUT(oe), .SERIAL_DOUT_OUT(sdo), .BUSY_OUT(busy), .HOLD_OUT(hold), .INT_REF_ON_OUT(iref),
    .CTRL_REG_OUT(creg), .CTRL_WRITE_OUT(wp));
  ahsp_core_mdl u_core (.clk_in(clk), .rst_in(rst), .busy_in(busy), .result_out(res));
  // Expected result of the k-th conversion
  function automatic logic [15:0] exp_res(input int k);
    return 16'ha5c0 + 16'(k);
  endfunction : exp_res
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic wr_ctl(input logic [7:0] v);
    cyc(1);
    db <= {v, 8'h00};
    cs_n <= 0;
    ws <= 0;
    cyc(1);
    cs_n <= 1;
    ws <= 1;
    @(negedge clk);
    check("pulse", 16'(wp), 16'(hw));
  endtask : wr_ctl
  task automatic start(input int p);
    cyc(1);
    cst[p] <= 1;
    cyc(1);
    cst[p] <= 0;
    @(negedge clk);
    check("hold", 16'(hold[p]), 16'h1);
  endtask : start
  task automatic wait_idle(input int n);
    int k;
    for (k = 0; k < 50 && busy; k++) begin
      @(negedge clk);
    end
    check("blen", 16'(k), 16'(n));
    check("busy", 16'(busy), 16'h0);
  endtask : wait_idle
  task automatic rd_par(input logic [15:0] e);
    cyc(1);
    cs_n <= 0;
    rd_n <= 0;
    cyc(2);
    cs_n <= 1;
    rd_n <= 1;
    @(negedge clk);
    check("oe", 16'(oe), 16'h1);
    check("data", dout, e);
    cyc(3);
    @(negedge clk);
    check("oe", 16'(oe), 16'h0);
  endtask : rd_par
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    logic [7:0] v;
    logic [15:0] w;
    {rst, cs_n, rd_n, ws, hw, ser, sclk, cst, db} = {4'hf, 3'h0, 3'h0, 16'h0000};
    void'($urandom(28317));
    cyc(10);
    rst <= 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ws <= 1'($urandom);
      cyc(1);
      @(negedge clk);
      check("iref", 16'(iref), 16'(ws));
    end
    $display("test pin reference done");
    cyc(1);
    hw <= 1;
    ws <= 1;
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr_ctl(v);
      check("ctrl", 16'(creg), 16'(v));
    end
    cyc(1);
    hw <= 0;
    wr_ctl(~v);
    check("ctrl", 16'(creg), 16'(v));
    $display("test control write done");
    start(0);
    wait_idle(CONV_N + 1);
    start(1);
    wait_idle(CONV_N + 1);
    start(2);
    cyc(20);
    @(negedge clk);
    check("full", 16'(busy), 16'h1);
    rd_par(exp_res(0));
    wait_idle(0);
    rd_par(exp_res(1));
    $display("test parallel read done");
    cyc(1);
    ser <= 1;
    rd_n <= 0;
    cyc(2);
    cs_n <= 0;
    cyc(3);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      w[i] = sdo;
      cyc(1);
      sclk <= 1;
      cyc(2);
      sclk <= 0;
      cyc(2);
    end
    check("serial", w, exp_res(2));
    check("oe", 16'(oe), 16'h0);
    $display("test serial read done");
    final_report();
  end
endmodule : adc_host_strobe_port_tb
